// file: amp_pkg.sv
// shared constants for the output amplifier control link
// Function
// [RULE_01] gain code 4 bits, exponential, 0..15
// [RULE_02] offset code 4 bits, linear between references
// [RULE_03] offset and gain codes stay independent
// [RULE_04] source select 1 routes external input
// [RULE_05] with converter: gain at least 3, offset low
// [RULE_06] dark level presented after each row
// [RULE_07] calibrate only in row or frame blanking
// [RULE_08] fast: calib plus unity, settle one cycle
// [RULE_09] hold input and offset during fast calibration
// [RULE_10] fast calibration once per frame, before readout
// [RULE_11] slow pulse falls with input at dark
// [RULE_12] one slow pulse per row blanking
// [RULE_13] default fast per image, slow for drift
// [RULE_14] pixel rate at most 10 Mpix/s; the row counter steps one pixel per clock and pix_cycles is unused
// [RULE_15] unity control 1 bypasses gain code
// [RULE_16] change codes only during blanking
package amp_pkg;
  localparam int code_width = 4;
  localparam logic [3:0] gain_min_conv = 4'h3;
  localparam logic [3:0] gain_reset = 4'h3;
  localparam logic [3:0] offset_low_ref = 4'h0;
  localparam logic [3:0] gain_top = 4'hF;
  localparam int clk_mhz = 200;
  localparam int max_pix_mhz = 10;
  // least clock cycles per pixel, rounded up
  localparam int pix_cycles = (clk_mhz + max_pix_mhz - 1) / max_pix_mhz;
  localparam int slow_pulse_cycles = 4;
  localparam int fast_cal_cycles = 4;
  localparam int settle_cycles = 1;
  localparam int slow_converge_pulses = 100;
  // apb register offsets
  localparam logic [7:0] reg_ctrl = 8'h00;
  localparam logic [7:0] reg_timing = 8'h04;
  localparam logic [7:0] reg_status = 8'h08;
  // ctrl fields
  localparam int ctrl_gain_lsb = 0;
  localparam int ctrl_offset_lsb = 4;
  localparam int ctrl_sel_ext = 8;
  localparam int ctrl_slow_mode = 9;
  localparam int ctrl_enable = 10;
  localparam int ctrl_conv_used = 11;
  // timing fields
  localparam int tim_row_lsb = 0;
  localparam int tim_blank_lsb = 16;
  localparam logic [15:0] row_pixels_reset = 16'h0500;
  localparam logic [15:0] blank_reset = 16'h0040;
  localparam logic [31:0] ctrl_reset = 32'h0000_0003;
endpackage

// file: amp_link_if.sv
// link between timing controller and amplifier control
`timescale 1ns/100ps
interface amp_link_if;
  logic [3:0] gain_code;
  logic [3:0] offset_code;
  logic sel_extin;
  logic unity_gain;
  logic calib_fast;
  logic calib_slow;
  logic row_active;
  logic dark_level;
  modport ctrl
  (
    output gain_code, offset_code, sel_extin, unity_gain,
    output calib_fast, calib_slow, row_active,
    input dark_level
  );
  modport amp
  (
    input gain_code, offset_code, sel_extin, unity_gain,
    input calib_fast, calib_slow, row_active,
    output dark_level
  );
endinterface

// file: pin_sync.sv
// two-stage synchroniser for a bundle of levels
`timescale 1ns/100ps
module pin_sync #(parameter int width = 1)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [width-1:0] din,
  output logic [width-1:0] dout
);
  logic [width-1:0] stage1;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      dout <= '0;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// file: amp_device.sv
// amplifier control end: decodes pins into analog switch settings
`timescale 1ns/100ps
module amp_device
(
  input wire logic mclk,
  input wire logic rst_n,
  amp_link_if.amp link,
  input wire logic row_done,
  output logic [3:0] gain_sel,
  output logic [3:0] offset_sel,
  output logic use_extin,
  output logic unity_fb,
  output logic offset_switch,
  output logic slow_switch,
  output logic offset_load,
  output logic [6:0] slow_count
);
  logic [11:0] raw;
  logic [11:0] pins;
  logic fast_d;
  assign raw = {link.gain_code, link.offset_code, link.sel_extin,
    link.unity_gain, link.calib_fast, link.calib_slow};
  pin_sync #(.width(12)) u_sync
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(raw),
    .dout(pins)
  );
  // gain and offset latched separately so neither disturbs the other
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      gain_sel <= 4'h0;
    else
      gain_sel <= pins[11:8]; // [RULE_01]
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      offset_sel <= 4'h0;
    else
      offset_sel <= pins[7:4]; // [RULE_02] [RULE_03]
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      use_extin <= 1'b0;
      unity_fb <= 1'b0;
      offset_switch <= 1'b0;
      slow_switch <= 1'b0;
    end
    else
    begin
      use_extin <= pins[3]; // [RULE_04]
      unity_fb <= pins[2]; // [RULE_15]
      offset_switch <= pins[1] & pins[2]; // [RULE_08]
      slow_switch <= pins[0];
    end
  end
  // offset stored on the falling edge of the fast control
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fast_d <= 1'b0;
      offset_load <= 1'b0;
    end
    else
    begin
      fast_d <= pins[1] & pins[2];
      offset_load <= fast_d & ~(pins[1] & pins[2]); // [RULE_08]
    end
  end
  // slow pulses counted up to convergence; saturates
  logic slow_d;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slow_d <= 1'b0;
      slow_count <= 7'h00;
    end
    else
    begin
      slow_d <= pins[0];
      if (pins[1] & pins[2])
        slow_count <= 7'h00;
      else if (slow_d && !pins[0] &&
        slow_count < 7'(amp_pkg::slow_converge_pulses))
        slow_count <= slow_count + 7'h01; // [RULE_12]
    end
  end
  // dark reference follows each completed row
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      link.dark_level <= 1'b0;
    else if (row_done)
      link.dark_level <= 1'b1; // [RULE_06]
    else if (link.row_active)
      link.dark_level <= 1'b0;
  end
endmodule

// file: amp_controller.sv
// timing controller end: apb registers and calibration sequencing
`timescale 1ns/100ps
module amp_controller
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_start,
  amp_link_if.ctrl link,
  output logic busy
);
  typedef enum logic [2:0]
  {
    st_idle = 3'b000,
    st_fast = 3'b110,
    st_row = 3'b011,
    st_blank = 3'b010,
    st_slow = 3'b111
  } state_type;
  state_type state;
  logic [31:0] ctrl;
  logic [31:0] timing;
  logic [15:0] count;
  logic fast_pending;
  logic [15:0] frames;
  logic frame_sync;
  logic frame_meta;
  logic frame_prev;
  logic frame_pulse;
  logic access;
  logic [3:0] gain_req;
  assign access = psel & penable;
  assign frame_pulse = frame_sync & ~frame_prev;
  // gain floor applied when the on-chip converter is in use
  assign gain_req = (ctrl[amp_pkg::ctrl_conv_used] &&
    ctrl[amp_pkg::ctrl_gain_lsb +: 4] < amp_pkg::gain_min_conv) ?
    amp_pkg::gain_min_conv : ctrl[amp_pkg::ctrl_gain_lsb +: 4]; // [RULE_05]

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_meta <= 1'b0;
      frame_sync <= 1'b0;
      frame_prev <= 1'b0;
    end
    else
    begin
      frame_meta <= frame_start;
      frame_sync <= frame_meta;
      frame_prev <= frame_sync;
    end
  end

  // registers: zero-wait apb slave
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= amp_pkg::ctrl_reset;
      timing <= {amp_pkg::blank_reset, amp_pkg::row_pixels_reset};
    end
    else if (access && pwrite)
    begin
      if (paddr == amp_pkg::reg_ctrl)
        ctrl <= {20'h00000, pwdata[11:0]};
      else if (paddr == amp_pkg::reg_timing)
        timing <= pwdata;
    end
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr != amp_pkg::reg_ctrl) &
        (paddr != amp_pkg::reg_timing) & (paddr != amp_pkg::reg_status);
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          amp_pkg::reg_ctrl: prdata <= ctrl;
          amp_pkg::reg_timing: prdata <= timing;
          amp_pkg::reg_status: prdata <= {frames, 9'h000, fast_pending,
            busy, state, link.dark_level, 1'b0};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // sequence: fast cal in first blanking, then rows with blanking gaps
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= st_idle;
      count <= 16'h0000;
      fast_pending <= 1'b0;
      frames <= 16'h0000;
    end
    else
    begin
      if (frame_pulse)
        fast_pending <= ~ctrl[amp_pkg::ctrl_slow_mode]; // [RULE_10] [RULE_13]
      case (state)
        st_idle:
          if (frame_pulse && ctrl[amp_pkg::ctrl_enable])
          begin
            state <= st_blank;
            count <= timing[amp_pkg::tim_blank_lsb +: 16];
            frames <= frames + 16'h0001;
          end
        st_blank:
          if (frame_pulse)
          begin
            // reload short of a full blank so slow mode cannot pulse twice
            if (ctrl[amp_pkg::ctrl_enable])
            begin
              count <= timing[amp_pkg::tim_blank_lsb +: 16] - 16'h0008;
              frames <= frames + 16'h0001;
            end
            else
              state <= st_idle;
          end
          else if (count == 16'h0000)
          begin
            state <= st_row;
            count <= timing[amp_pkg::tim_row_lsb +: 16];
          end
          else if (fast_pending &&
            count > 16'(amp_pkg::fast_cal_cycles + 1))
          begin
            state <= st_fast; // [RULE_07] [RULE_10]
            count <= 16'(amp_pkg::fast_cal_cycles);
            fast_pending <= 1'b0;
          end
          else if (ctrl[amp_pkg::ctrl_slow_mode] && !fast_pending &&
            count == timing[amp_pkg::tim_blank_lsb +: 16])
          begin
            state <= st_slow; // [RULE_12] [RULE_11]
            count <= 16'(amp_pkg::slow_pulse_cycles);
          end
          else
            count <= count - 16'h0001;
        st_fast, st_slow:
          if (count == 16'h0000)
          begin
            state <= st_blank;
            count <= timing[amp_pkg::tim_blank_lsb +: 16] - 16'h0008;
          end
          else
            count <= count - 16'h0001;
        st_row:
          if (frame_pulse)
          begin
            // a new frame cuts the current row and restarts in blanking
            if (ctrl[amp_pkg::ctrl_enable])
            begin
              state <= st_blank;
              count <= timing[amp_pkg::tim_blank_lsb +: 16];
              frames <= frames + 16'h0001;
            end
            else
              state <= st_idle;
          end
          else if (count == 16'h0000)
          begin
            state <= st_blank;
            count <= timing[amp_pkg::tim_blank_lsb +: 16];
          end
          else
            count <= count - 16'h0001;
        default:
          state <= st_idle;
      endcase
    end
  end

  // pins: settings change only outside active rows
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.gain_code <= amp_pkg::gain_reset;
      link.offset_code <= amp_pkg::offset_low_ref;
      link.sel_extin <= 1'b0;
    end
    else if (state == st_blank || state == st_idle)
    begin
      link.gain_code <= gain_req; // [RULE_16]
      link.offset_code <= ctrl[amp_pkg::ctrl_conv_used] ?
        amp_pkg::offset_low_ref : ctrl[amp_pkg::ctrl_offset_lsb +: 4];
      link.sel_extin <= ctrl[amp_pkg::ctrl_sel_ext];
    end
  end
  // fast: calib held until one cycle before exit so unity outlasts it
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.unity_gain <= 1'b0;
      link.calib_fast <= 1'b0;
      link.calib_slow <= 1'b0;
      link.row_active <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      link.unity_gain <= (state == st_fast); // [RULE_08] [RULE_09]
      link.calib_fast <= (state == st_fast) && count != 16'h0000;
      link.calib_slow <= (state == st_slow) && count > 16'h0001;
      link.row_active <= (state == st_row); // [RULE_14]
      busy <= (state == st_fast) || (state == st_slow);
    end
  end
endmodule

// file: amp_link_monitor.sv
// checker watching the amplifier control link
`timescale 1ns/100ps
module amp_link_monitor
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] gain_code,
  input wire logic [3:0] offset_code,
  input wire logic sel_extin,
  input wire logic unity_gain,
  input wire logic calib_fast,
  input wire logic calib_slow,
  input wire logic row_active,
  input wire logic dark_level
);
  logic [1:0] slow_n;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // slow pulses since the last row or fast calibration; saturates at 3
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      slow_n <= 2'h0;
    else if (row_active || calib_fast)
      slow_n <= 2'h0;
    else if ($rose(calib_slow) && slow_n != 2'h3)
      slow_n <= slow_n + 2'h1;
  a_fast_unity_rise: assert property (
    $rose(calib_fast) |-> $rose(unity_gain))
    else $error("fast calibrate rose without unity");
  a_unity_trail: assert property (
    $fell(calib_fast) |-> unity_gain ##1 !unity_gain)
    else $error("unity did not trail fast calibrate by one cycle");
  a_unity_only_cal: assert property (
    unity_gain |-> calib_fast || $past(calib_fast))
    else $error("unity feedback outside fast calibration");
  a_cal_in_blank: assert property (
    calib_fast || calib_slow |-> !row_active)
    else $error("calibration during active row");
  a_fast_hold: assert property (
    calib_fast && $past(calib_fast) |->
      $stable(offset_code) && $stable(sel_extin))
    else $error("input or offset moved in fast calibration");
  a_row_codes_static: assert property (
    row_active && $past(row_active) |->
      $stable({gain_code, offset_code, sel_extin}))
    else $error("codes changed during active row");
  a_slow_width: assert property (
    $rose(calib_slow) |-> ##[1:8] !calib_slow)
    else $error("slow pulse too long");
  a_one_slow_blank: assert property (
    slow_n < 2'h2)
    else $error("two slow pulses in one blanking");
  a_reset_codes: assert property (
    $rose(rst_n) |-> gain_code == 4'h3 && offset_code == 4'h0)
    else $error("link codes wrong after reset");
endmodule

// file: output_amp_gain_offset_calibration_tb.sv
// self-checking bench joining controller and amplifier ends
`timescale 1ns/100ps
module output_amp_gain_offset_calibration_tb;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic frame_start = 1'h0;
  logic row_done = 1'h0;
  logic [31:0] prdata;
  logic pready, pslverr, busy, use_extin, unity_fb, offset_switch;
  logic slow_switch, offset_load;
  logic [3:0] gain_sel, offset_sel, g, o;
  logic [6:0] slow_count;
  logic [33:0] e;
  logic [33:0] expq[$];
  int fails = 0;
  int checked = 0;
  int ldn = 0;
  amp_link_if link();
  amp_controller amp_controller_inst (.mclk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .frame_start,
    .link(link.ctrl), .busy);
  amp_device amp_device_inst (.mclk, .rst_n, .link(link.amp), .row_done,
    .gain_sel, .offset_sel, .use_extin, .unity_fb, .offset_switch,
    .slow_switch, .offset_load, .slow_count);
  amp_link_monitor amp_link_monitor_inst (.mclk, .rst_n,
    .gain_code(link.gain_code), .offset_code(link.offset_code),
    .sel_extin(link.sel_extin), .unity_gain(link.unity_gain),
    .calib_fast(link.calib_fast), .calib_slow(link.calib_slow),
    .row_active(link.row_active), .dark_level(link.dark_level));
  always #2.5 mclk = ~mclk;
  task automatic tally_and_finish;
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // e = {write, slverr, read data}
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [33:0] x);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    expq.push_back(x);
    @(posedge mclk);
    penable <= 1'h1;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do @(posedge mclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'h1, a, d, {2'h2, 32'h0});
  endtask
  task automatic rd(logic [7:0] a, logic [32:0] x);
    apb(1'h0, a, 32'h0, {1'h0, x});
  endtask
  // first rows start after the frame's blanking, so codes are settled
  task automatic frame;
    @(posedge mclk);
    frame_start <= 1'h1;
    repeat (4) @(posedge mclk);
    frame_start <= 1'h0;
    repeat (8) @(posedge mclk);
    @(posedge link.row_active);
    repeat (2) @(posedge mclk);
  endtask
  always @(posedge mclk)
    if (offset_load === 1'h1)
      ldn++;
  always @(posedge mclk)
    if (psel && penable && pready === 1'h1 && expq.size() > 0)
    begin
      e = expq.pop_front();
      cmp("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      if (!e[33])
        cmp("prdata", e[31:0], prdata);
    end
  initial
  begin
    #(5 * 5000);
    fails++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(69));
    repeat (16) @(posedge mclk);
    rst_n <= 1'h1;
    rd(amp_pkg::reg_ctrl, {1'h0, 32'h3});
    rd(amp_pkg::reg_timing, {1'h0, 32'h0040_0500});
    apb(1'h1, 8'h0C, 32'hFFFF_FFFF, {2'h3, 32'h0});
    rd(8'h0C, {1'h1, 32'h0});
    wr(amp_pkg::reg_timing, 32'h0020_0040);
    rd(amp_pkg::reg_timing, {1'h0, 32'h0020_0040});
    repeat (4)
    begin
      g = 4'($urandom);
      o = 4'($urandom);
      wr(amp_pkg::reg_ctrl, {24'h0, o, g});
      rd(amp_pkg::reg_ctrl, {25'h0, o, g});
    end
    wr(amp_pkg::reg_ctrl, {24'h5, o, g});
    frame();
    cmp("gain_sel", 32'(g), 32'(gain_sel));
    cmp("offset_sel", 32'(o), 32'(offset_sel));
    cmp("use_extin", 32'h1, 32'(use_extin));
    cmp("loads", 32'h1, ldn);
    cmp("unity_fb", 32'h0, 32'(unity_fb));
    cmp("offset_switch", 32'h0, 32'(offset_switch));
    cmp("slow_switch", 32'h0, 32'(slow_switch));
    cmp("busy", 32'h0, 32'(busy));
    // one frame counted, mid-row, no calibration pending or running
    rd(amp_pkg::reg_status, {1'h0, 32'h0001_000C});
    wr(amp_pkg::reg_ctrl, 32'h0000_0C51);
    frame();
    cmp("gain_sel", 32'h3, 32'(gain_sel));
    cmp("offset_sel", 32'h0, 32'(offset_sel));
    cmp("use_extin", 32'h0, 32'(use_extin));
    wr(amp_pkg::reg_ctrl, 32'h0000_0600);
    frame();
    repeat (3) @(negedge link.row_active);
    @(posedge link.row_active);
    repeat (8) @(posedge mclk);
    cmp("slow_count", 32'h4, 32'(slow_count));
    cmp("loads", 32'h2, ldn);
    wr(amp_pkg::reg_ctrl, 32'h0000_0400);
    frame();
    cmp("slow_count", 32'h0, 32'(slow_count));
    cmp("loads", 32'h3, ldn);
    // dark level is only meaningful once the row has ended
    @(negedge link.row_active);
    @(posedge mclk);
    row_done <= 1'h1;
    @(posedge mclk);
    row_done <= 1'h0;
    repeat (4) @(posedge mclk);
    cmp("dark_level", 32'h1, 32'(link.dark_level));
    tally_and_finish();
  end
endmodule
